/* bench/keypad_operator.sv */
// Keypad operator model that presses star or pound while reading a channel
`timescale 1ns/1ps
module keypad_operator (
	input wire logic clk_i,
	input wire logic key_ready_i,
	output logic key_valid_o,
	output logic key_pound_o,
	output logic [3:0] key_chan_o,
	output logic user_access_o
);
	initial begin
		key_valid_o = 1'b0;
		key_pound_o = 1'b0;
		key_chan_o = 4'h0;
		user_access_o = 1'b0;
	end
	// Pound asks for switch B, star for switch A; gap lets the operator be slow
	task automatic press(input int gap, input logic acc, input logic pound, input logic [3:0] ch);
		repeat (gap) @(posedge clk_i);
		user_access_o <= acc;
		key_valid_o <= 1'b1;
		key_pound_o <= pound;
		key_chan_o <= ch;
		do @(posedge clk_i); while (key_ready_i !== 1'b1);
		key_valid_o <= 1'b0;
		// Released lines show the inverse so stale values cannot pass
		key_pound_o <= ~pound;
		key_chan_o <= ~ch;
		repeat (4) @(posedge clk_i);
	endtask
endmodule

/* bench/limit_monitor_props.sv */
// Checker of the limit monitor port behaviour, bound into the design
`timescale 1ns/1ps
module limit_monitor_props #(
	parameter int CHANNELS = 16
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire logic sample_valid_i,
	input wire logic sample_ready_o,
	input wire logic key_valid_i,
	input wire logic key_pound_i,
	input wire logic user_access_i,
	input wire logic key_ready_o,
	input wire logic cmd_valid_o,
	input wire logic [6:0] cmd_chan_o,
	input wire logic cmd_b_o,
	input wire logic dial_valid_o,
	input wire logic [3:0] dial_chan_o,
	input wire logic [CHANNELS-1:0] alarm_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);
	logic key_take, smp_take, pound_seen;
	logic [CHANNELS-1:0] alarm_prev;
	assign key_take = key_valid_i && key_ready_o;
	assign smp_take = sample_valid_i && sample_ready_o;
	// Key taken and its command can be two or three edges apart
	always_ff @(posedge clk_i) begin
		// Indexed by the current dial channel, not the one of a cycle ago
		alarm_prev <= alarm_o;
		if (key_take) begin
			pound_seen <= key_pound_i;
		end
	end
	a_pready_req: assert property (pready_o |-> psel_i && penable_i) else $error("pready without access");
	a_pslverr_qual: assert property (pslverr_o |-> pready_o) else $error("pslverr without pready");
	a_cmd_range: assert property (cmd_valid_o |-> cmd_chan_o != 7'h00 && cmd_chan_o <= 7'h63) else $error("bad command channel");
	a_key_ignored: assert property (key_take && !user_access_i |-> ##2 !cmd_valid_o [*2]) else $error("key fired outside user access");
	a_key_switch: assert property (cmd_valid_o && ($past(key_take, 2) || $past(key_take, 3)) |-> cmd_b_o == pound_seen) else $error("wrong switch for key");
	a_cmd_cause: assert property (cmd_valid_o |-> $past(key_take, 2) || $past(key_take, 3) || $past(smp_take, 6) || $past(smp_take, 7)) else $error("command without cause");
	a_dial_alarm: assert property (dial_valid_o |-> alarm_o[dial_chan_o] && !alarm_prev[dial_chan_o]) else $error("dial without new alarm");
	a_alarm_cause: assert property ($changed(alarm_o) |-> $past(smp_take, 6) || $past(smp_take, 7)) else $error("alarm moved without sample");
	cover property (dial_valid_o);
endmodule
bind limit_monitor limit_monitor_props #(.CHANNELS(CHANNELS)) props (.clk_i(clk_i), .reset_i(reset_i),
	.psel_i(psel_i), .penable_i(penable_i), .prdata_o(prdata_o), .pready_o(pready_o),
	.pslverr_o(pslverr_o), .sample_valid_i(sample_valid_i), .sample_ready_o(sample_ready_o),
	.key_valid_i(key_valid_i), .key_pound_i(key_pound_i), .user_access_i(user_access_i),
	.key_ready_o(key_ready_o), .cmd_valid_o(cmd_valid_o), .cmd_chan_o(cmd_chan_o),
	.cmd_b_o(cmd_b_o), .dial_valid_o(dial_valid_o), .dial_chan_o(dial_chan_o), .alarm_o(alarm_o));

/* bench/test_limit_monitor.sv */
// Self-checking bench of the metering limit monitor
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
	$display("MISMATCH %s expected %h seen %h", n, e, g); end end
module test_limit_monitor;
	logic clk_i = 1'b0, reset_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
	logic [monitor_pkg::ADDR_W-1:0] paddr_i = 12'h000;
	logic [31:0] pwdata_i = 32'h00000000, prdata_o, rd;
	logic pready_o, pslverr_o, err, sample_valid_i = 1'b0, sample_ready_o;
	logic [3:0] sample_chan_i = 4'h0, key_chan_i, dial_sel_o, dial_chan_o;
	logic [15:0] sample_i = 16'h0000, alarm_o;
	logic key_valid_i, key_pound_i, user_access_i, key_ready_o, cmd_valid_o, cmd_b_o, dial_valid_o;
	logic [6:0] cmd_chan_o;
	int n_errors = 0, comparisons = 0, n_cmd = 0, n_dial = 0, cyc = 0, k, d;
	always #4 clk_i = ~clk_i;
	limit_monitor #(.TICK_CYCLES(10)) dut (.clk_i(clk_i), .reset_i(reset_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
		.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
		.sample_valid_i(sample_valid_i), .sample_chan_i(sample_chan_i), .sample_i(sample_i),
		.sample_ready_o(sample_ready_o), .key_valid_i(key_valid_i), .key_pound_i(key_pound_i),
		.key_chan_i(key_chan_i), .user_access_i(user_access_i), .key_ready_o(key_ready_o),
		.cmd_valid_o(cmd_valid_o), .cmd_chan_o(cmd_chan_o), .cmd_b_o(cmd_b_o),
		.dial_valid_o(dial_valid_o), .dial_sel_o(dial_sel_o), .dial_chan_o(dial_chan_o),
		.alarm_o(alarm_o));
	keypad_operator op (.clk_i(clk_i), .key_ready_i(key_ready_o), .key_valid_o(key_valid_i),
		.key_pound_o(key_pound_i), .key_chan_o(key_chan_i), .user_access_o(user_access_i));
	task automatic end_of_test();
		$display("n_errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// Pulses are counted so that repeats and absences can both be judged
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cmd_valid_o === 1'b1) n_cmd <= n_cmd + 1;
		if (dial_valid_o === 1'b1) n_dial <= n_dial + 1;
		if (cyc == 6000) begin
			n_errors++;
			end_of_test();
		end
	end
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= wd;
		@(posedge clk_i);
		penable_i <= 1'b1;
		do @(posedge clk_i); while (pready_o !== 1'b1);
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		// Idle edge so a following call never lowers and raises psel in one step
		@(posedge clk_i);
	endtask
	task automatic run(input logic [3:0] c, input logic [15:0] v, input int n);
		repeat (n) begin
			sample_valid_i <= 1'b1;
			sample_chan_i <= c;
			sample_i <= v;
			do @(posedge clk_i); while (sample_ready_o !== 1'b1);
			sample_valid_i <= 1'b0;
			repeat (8) @(posedge clk_i);
		end
	endtask
	initial begin
		repeat (2) @(posedge clk_i);
		reset_i <= 1'b0;
		apb(0, 12'h000, 0); `CHK("cfg_def", 32'h00000100, rd)
		apb(0, 12'h004, 0); `CHK("low2_def", 32'h0000D8F1, rd)
		apb(0, 12'h008, 0); `CHK("low1_def", 32'h0000D8F1, rd)
		apb(0, 12'h00C, 0); `CHK("high1_def", 32'h0000270F, rd)
		apb(0, 12'h1E4, 0); `CHK("ch15_low2", 32'h0000D8F1, rd)
		apb(0, 12'h014, 0); `CHK("unmapped_err", 1'b1, err)
		apb(1, 12'h200, 32'h00000005); `CHK("ro_err", 1'b1, err)
		apb(1, 12'h028, 32'h00007FFF);
		apb(0, 12'h028, 0); `CHK("limit_clamp", 32'h0000270F, rd)
		apb(1, 12'h020, 32'h000F7F7F);
		apb(0, 12'h020, 0); `CHK("cfg_clamp", 32'h00096363, rd)
		apb(1, 12'h060, 32'h0000010A);
		op.press(0, 1, 1, 4'h3); `CHK("key_b", 8'h8A, {cmd_b_o, cmd_chan_o})
		op.press(3, 1, 0, 4'h3); `CHK("key_a", 8'h0A, {cmd_b_o, cmd_chan_o})
		k = n_cmd;
		op.press(0, 0, 1, 4'h3); `CHK("key_noaccess", k, n_cmd)
		op.press(0, 1, 1, 4'h4); `CHK("key_nodefault", k, n_cmd)
		apb(1, 12'h0B0, 32'h00000800);
		apb(1, 12'h0A4, 32'h0187FF9C);
		apb(1, 12'h0A0, 32'h00030200);
		k = n_cmd;
		d = n_dial;
		run(4'h5, 16'hFFC4, 1); `CHK("delay_hold", k, n_cmd)
		run(4'h5, 16'hFFC4, 6); `CHK("auto_repeat", 1'b1, (n_cmd - k) > 1)
		`CHK("low2_cmd", 8'h87, {cmd_b_o, cmd_chan_o})
		`CHK("low2_alarm", 1'b1, alarm_o[5])
		`CHK("dial_once", d + 1, n_dial)
		`CHK("dial_one", 8'h35, {dial_sel_o, dial_chan_o})
		run(4'h5, 16'h0000, 1); `CHK("alarm_clear", 1'b0, alarm_o[5])
		k = n_cmd;
		run(4'h5, 16'hFFC4, 1); `CHK("delay_restart", k, n_cmd)
		apb(1, 12'h0E8, 32'h009EFFCE);
		run(4'h7, 16'hFFB0, 4); `CHK("low1_cmd", 8'h9E, {cmd_b_o, cmd_chan_o})
		`CHK("low1_noalarm", 1'b0, alarm_o[7])
		apb(1, 12'h0CC, 32'h01140064);
		d = n_dial;
		run(4'h6, 16'h00C8, 4); `CHK("high1_cmd", 8'h14, {cmd_b_o, cmd_chan_o})
		`CHK("dial_all", 8'h06, {dial_sel_o, dial_chan_o})
		`CHK("dial_n", d + 1, n_dial)
		apb(0, 12'h200, 0);
		`CHK("alarm_reg", 32'h00000040, rd)
		apb(0, 12'h204, 0);
		`CHK("passed_reg", 32'h000000E0, rd)
		end_of_test();
	end
endmodule

/* hdl/limit_monitor.sv */
// Metering limit monitor: per-channel limits, alarm delay, auto commands and dial requests
// Overview of operation
// - Any command channel may be channel default
// - User star fires A, pound fires B
// - Default command two digits; zero means none
// - Alarm delay 1 to 99 s, default one
// - Commands repeat until value returns nominal
// - Alarm dials one number or all numbers
// - Dial digit zero means all, n means n
// - Limits compare sample times calibration constant
// - Second low limit fires its command
// - Limit command two digits; zero disables; default off
// - Second low alarm enable, default disabled
// - First low like second; both default minimum
// - First low limit fires its command
// - First low alarm enable, default disabled
// - First high defaults maximum, which disables it
// - First high limit fires its command
// - Sixteen channels each with own parameters
// - Limits hold minus to plus 9999
// - First high alarm enable, default disabled
`timescale 1ns/1ps
module limit_monitor #(
	parameter int CHANNELS = monitor_pkg::CHANNELS,
	parameter int TICK_CYCLES = monitor_pkg::TICK_CYCLES
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [monitor_pkg::ADDR_W-1:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic sample_valid_i,
	input wire logic [3:0] sample_chan_i,
	input wire logic [15:0] sample_i,
	output logic sample_ready_o,
	input wire logic key_valid_i,
	input wire logic key_pound_i,
	input wire logic [3:0] key_chan_i,
	input wire logic user_access_i,
	output logic key_ready_o,
	output logic cmd_valid_o,
	output logic [6:0] cmd_chan_o,
	output logic cmd_b_o,
	output logic dial_valid_o,
	output logic [3:0] dial_sel_o,
	output logic [3:0] dial_chan_o,
	output logic [CHANNELS-1:0] alarm_o
);
	typedef struct packed {
		monitor_pkg::state_e st;
		logic [6:0] init_idx;
		logic [2:0] word;
		logic [3:0] chan;
		logic [15:0] sample;
		logic [31:0] cfg;
		logic [31:0] low2;
		logic [31:0] low1;
		logic [31:0] high1;
		logic [31:0] prdata;
		logic pslverr;
		logic [CHANNELS-1:0] passed;
		logic [CHANNELS-1:0] alarm;
		logic [CHANNELS-1:0][6:0] secs;
		logic cmd_valid;
		logic [6:0] cmd_chan;
		logic cmd_b;
		logic key_b;
		logic dial_valid;
		logic [3:0] dial_sel;
		logic [3:0] dial_chan;
	} mon_s;

	mon_s q;
	mon_s next_q;

	logic tick;
	logic we;
	logic [6:0] wr_addr;
	logic [31:0] wr_data;
	logic [6:0] rd_addr;
	logic [31:0] rdata;
	logic apb_acc;
	logic in_chan;
	logic [11:0] word_addr;
	logic signed [31:0] prod;
	logic [15:0] value;
	logic pass2;
	logic pass1;
	logic passh;
	logic armed;
	logic alarm_hit;
	logic [6:0] ch_delay;

	function automatic logic [15:0] sat_limit(input logic signed [31:0] x);
		logic [15:0] r;
		r = x[15:0];
		if (x > $signed(monitor_pkg::LIMIT_MAX)) begin
			r = monitor_pkg::LIMIT_MAX;
		end else if (x < $signed(monitor_pkg::LIMIT_MIN)) begin
			r = monitor_pkg::LIMIT_MIN;
		end
		return r;
	endfunction

	function automatic logic [6:0] clamp_cmd(input logic [6:0] v);
		return (v > monitor_pkg::CMD_MAX) ? monitor_pkg::CMD_MAX : v;
	endfunction

	// Reset contents of one parameter word
	function automatic logic [31:0] default_word(input logic [2:0] word);
		logic [31:0] w;
		w = 32'h0000_0000;
		case (word)
			monitor_pkg::WORD_CFG: begin
				w[monitor_pkg::CFG_DELAY_LSB +: 7] = monitor_pkg::DELAY_DEF;
				w[monitor_pkg::CFG_DEF_LSB +: 7] = monitor_pkg::CMD_NONE;
				w[monitor_pkg::CFG_DIAL_LSB +: 4] = monitor_pkg::DIAL_ALL;
			end
			monitor_pkg::WORD_LOW2, monitor_pkg::WORD_LOW1: begin
				w[monitor_pkg::LIM_VAL_LSB +: 16] = monitor_pkg::LIMIT_MIN;
			end
			monitor_pkg::WORD_HIGH1: begin
				w[monitor_pkg::LIM_VAL_LSB +: 16] = monitor_pkg::LIMIT_MAX;
			end
			monitor_pkg::WORD_CAL: begin
				w[15:0] = monitor_pkg::CAL_DEF;
			end
			default: begin
				w = 32'h0000_0000;
			end
		endcase
		return w;
	endfunction

	// Software values are forced into the legal digit ranges before storage
	function automatic logic [31:0] clean_word(input logic [2:0] word, input logic [31:0] d);
		logic [31:0] w;
		logic [6:0] v;
		logic [3:0] dl;
		w = 32'h0000_0000;
		v = d[monitor_pkg::CFG_DELAY_LSB +: 7];
		dl = d[monitor_pkg::CFG_DIAL_LSB +: 4];
		case (word)
			monitor_pkg::WORD_CFG: begin
				w[monitor_pkg::CFG_DEF_LSB +: 7] = clamp_cmd(d[monitor_pkg::CFG_DEF_LSB +: 7]);
				if (v < monitor_pkg::DELAY_MIN) begin
					v = monitor_pkg::DELAY_MIN;
				end else if (v > monitor_pkg::DELAY_MAX) begin
					v = monitor_pkg::DELAY_MAX;
				end
				w[monitor_pkg::CFG_DELAY_LSB +: 7] = v;
				w[monitor_pkg::CFG_DIAL_LSB +: 4] = (dl > monitor_pkg::DIAL_MAX) ?
					monitor_pkg::DIAL_MAX : dl;
			end
			monitor_pkg::WORD_LOW2, monitor_pkg::WORD_LOW1, monitor_pkg::WORD_HIGH1: begin
				w[monitor_pkg::LIM_VAL_LSB +: 16] =
					sat_limit(32'($signed(d[monitor_pkg::LIM_VAL_LSB +: 16])));
				w[monitor_pkg::LIM_CMD_LSB +: 7] = clamp_cmd(d[monitor_pkg::LIM_CMD_LSB +: 7]);
				w[monitor_pkg::LIM_SWB_BIT] = d[monitor_pkg::LIM_SWB_BIT];
				w[monitor_pkg::LIM_ALEN_BIT] = d[monitor_pkg::LIM_ALEN_BIT];
			end
			monitor_pkg::WORD_CAL: begin
				w[15:0] = d[15:0];
			end
			default: begin
				w = 32'h0000_0000;
			end
		endcase
		return w;
	endfunction

	second_tick #(
		.CYCLES(TICK_CYCLES)
	) u_tick (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.tick_o(tick)
	);

	param_store #(
		.WIDTH(32),
		.DEPTH(128)
	) u_store (
		.clk_i(clk_i),
		.we_i(we),
		.waddr_i(wr_addr),
		.wdata_i(wr_data),
		.raddr_i(rd_addr),
		.rdata_o(rdata)
	);

	assign apb_acc = psel_i & penable_i;
	assign word_addr = {paddr_i[11:2], 2'b00};
	assign in_chan = (paddr_i[11:9] == 3'h0) && (paddr_i[4:2] <= monitor_pkg::WORD_CAL);

	// Scaled value, saturated to the range the limits can hold
	assign prod = $signed(q.sample) * $signed(rdata[15:0]);
	assign value = sat_limit(prod >>> monitor_pkg::CAL_FRAC);
	assign pass2 = $signed(value) < $signed(q.low2[monitor_pkg::LIM_VAL_LSB +: 16]);
	assign pass1 = $signed(value) < $signed(q.low1[monitor_pkg::LIM_VAL_LSB +: 16]);
	assign passh = $signed(value) > $signed(q.high1[monitor_pkg::LIM_VAL_LSB +: 16]);
	assign ch_delay = q.cfg[monitor_pkg::CFG_DELAY_LSB +: 7];
	assign armed = q.secs[q.chan] >= ch_delay;
	assign alarm_hit = (pass2 & q.low2[monitor_pkg::LIM_ALEN_BIT])
		| (pass1 & q.low1[monitor_pkg::LIM_ALEN_BIT])
		| (passh & q.high1[monitor_pkg::LIM_ALEN_BIT]);

	// Bus has priority over the keypad, the keypad over samples
	assign pready_o = ((q.st == monitor_pkg::S_IDLE) & apb_acc & pwrite_i)
		| (q.st == monitor_pkg::S_APB_DONE);
	assign pslverr_o = (q.st == monitor_pkg::S_APB_DONE) ? q.pslverr :
		((q.st == monitor_pkg::S_IDLE) & apb_acc & pwrite_i & ~in_chan);
	assign key_ready_o = (q.st == monitor_pkg::S_IDLE) & ~apb_acc;
	assign sample_ready_o = key_ready_o & ~key_valid_i;

	always_comb begin
		next_q = q;
		next_q.cmd_valid = 1'b0;
		next_q.dial_valid = 1'b0;
		we = 1'b0;
		wr_addr = {paddr_i[8:5], paddr_i[4:2]};
		wr_data = clean_word(paddr_i[4:2], pwdata_i);
		rd_addr = {q.chan, q.word};

		// Only channels still beyond a limit keep counting seconds
		if (tick) begin
			for (int i = 0; i < CHANNELS; i++) begin
				if (q.passed[i] && (q.secs[i] < monitor_pkg::DELAY_MAX)) begin
					next_q.secs[i] = q.secs[i] + 7'h01;
				end
			end
		end

		case (q.st)
			monitor_pkg::S_INIT: begin
				we = 1'b1;
				wr_addr = q.init_idx;
				wr_data = default_word(q.init_idx[2:0]);
				next_q.init_idx = q.init_idx + 7'h01;
				if (q.init_idx == 7'h7F) begin
					next_q.st = monitor_pkg::S_IDLE;
				end
			end
			monitor_pkg::S_IDLE: begin
				if (apb_acc) begin
					if (pwrite_i) begin
						we = in_chan;
					end else begin
						rd_addr = {paddr_i[8:5], paddr_i[4:2]};
						next_q.st = monitor_pkg::S_APB_RD;
					end
				end else if (key_valid_i) begin
					rd_addr = {key_chan_i, monitor_pkg::WORD_CFG};
					next_q.chan = key_chan_i;
					// Switch held aside so an ignored key leaves cmd_b_o alone
					next_q.key_b = key_pound_i;
					if (user_access_i) begin
						next_q.st = monitor_pkg::S_KEY_DO;
					end
				end else if (sample_valid_i) begin
					rd_addr = {sample_chan_i, monitor_pkg::WORD_CFG};
					next_q.chan = sample_chan_i;
					next_q.sample = sample_i;
					next_q.word = monitor_pkg::WORD_LOW2;
					next_q.st = monitor_pkg::S_EV_RD;
				end
			end
			monitor_pkg::S_APB_RD: begin
				next_q.pslverr = 1'b0;
				if (in_chan) begin
					next_q.prdata = rdata;
				end else if (word_addr == monitor_pkg::ADDR_ALARM) begin
					next_q.prdata = 32'(q.alarm);
				end else if (word_addr == monitor_pkg::ADDR_PASSED) begin
					next_q.prdata = 32'(q.passed);
				end else begin
					next_q.prdata = 32'h0000_0000;
					next_q.pslverr = 1'b1;
				end
				next_q.st = monitor_pkg::S_APB_DONE;
			end
			monitor_pkg::S_APB_DONE: begin
				next_q.st = monitor_pkg::S_IDLE;
			end
			monitor_pkg::S_KEY_DO: begin
				// Star fires switch A, pound switch B; zero means no default channel
				if (rdata[monitor_pkg::CFG_DEF_LSB +: 7] != monitor_pkg::CMD_NONE) begin
					next_q.cmd_valid = 1'b1;
					next_q.cmd_chan = rdata[monitor_pkg::CFG_DEF_LSB +: 7];
					next_q.cmd_b = q.key_b;
				end
				next_q.st = monitor_pkg::S_IDLE;
			end
			monitor_pkg::S_EV_RD: begin
				// Read data lags the address by one cycle
				case (q.word)
					monitor_pkg::WORD_LOW2: next_q.cfg = rdata;
					monitor_pkg::WORD_LOW1: next_q.low2 = rdata;
					monitor_pkg::WORD_HIGH1: next_q.low1 = rdata;
					default: next_q.high1 = rdata;
				endcase
				if (q.word == monitor_pkg::WORD_CAL) begin
					next_q.st = monitor_pkg::S_EV_CMP;
				end else begin
					next_q.word = q.word + 3'h1;
				end
			end
			monitor_pkg::S_EV_CMP: begin
				if (!(pass2 | pass1 | passh)) begin
					next_q.passed[q.chan] = 1'b0;
					next_q.secs[q.chan] = 7'h00;
					next_q.alarm[q.chan] = 1'b0;
				end else begin
					next_q.passed[q.chan] = 1'b1;
					// Every sample seen past the delay re-issues the command
					if (armed) begin
						if (pass2 && q.low2[monitor_pkg::LIM_CMD_LSB +: 7] != monitor_pkg::CMD_NONE) begin
							next_q.cmd_valid = 1'b1;
							next_q.cmd_chan = q.low2[monitor_pkg::LIM_CMD_LSB +: 7];
							next_q.cmd_b = q.low2[monitor_pkg::LIM_SWB_BIT];
						end else if (pass1 &&
							q.low1[monitor_pkg::LIM_CMD_LSB +: 7] != monitor_pkg::CMD_NONE) begin
							next_q.cmd_valid = 1'b1;
							next_q.cmd_chan = q.low1[monitor_pkg::LIM_CMD_LSB +: 7];
							next_q.cmd_b = q.low1[monitor_pkg::LIM_SWB_BIT];
						end else if (passh &&
							q.high1[monitor_pkg::LIM_CMD_LSB +: 7] != monitor_pkg::CMD_NONE) begin
							next_q.cmd_valid = 1'b1;
							next_q.cmd_chan = q.high1[monitor_pkg::LIM_CMD_LSB +: 7];
							next_q.cmd_b = q.high1[monitor_pkg::LIM_SWB_BIT];
						end
						next_q.alarm[q.chan] = alarm_hit;
						// Dialing starts only on a newly declared alarm
						if (alarm_hit && !q.alarm[q.chan]) begin
							next_q.dial_valid = 1'b1;
							next_q.dial_sel = q.cfg[monitor_pkg::CFG_DIAL_LSB +: 4];
							next_q.dial_chan = q.chan;
						end
					end
				end
				next_q.st = monitor_pkg::S_IDLE;
			end
			default: begin
				next_q.st = monitor_pkg::S_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			q <= '0;
			q.st <= monitor_pkg::S_INIT;
		end else begin
			q <= next_q;
		end
	end

	assign prdata_o = q.prdata;
	assign cmd_valid_o = q.cmd_valid;
	assign cmd_chan_o = q.cmd_chan;
	assign cmd_b_o = q.cmd_b;
	assign dial_valid_o = q.dial_valid;
	assign dial_sel_o = q.dial_sel;
	assign dial_chan_o = q.dial_chan;
	assign alarm_o = q.alarm;
endmodule

/* hdl/monitor_pkg.sv */
// Shared constants, field layout and state encoding of the metering limit monitor
package monitor_pkg;
	localparam int CHANNELS = 16;
	localparam int CLK_PERIOD_NS = 8;
	localparam int TICK_PERIOD_NS = 1000000000;
	localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

	localparam int ADDR_W = 12;
	localparam logic [11:0] ADDR_ALARM = 12'h200;
	localparam logic [11:0] ADDR_PASSED = 12'h204;

	localparam logic [2:0] WORD_CFG = 3'h0;
	localparam logic [2:0] WORD_LOW2 = 3'h1;
	localparam logic [2:0] WORD_LOW1 = 3'h2;
	localparam logic [2:0] WORD_HIGH1 = 3'h3;
	localparam logic [2:0] WORD_CAL = 3'h4;

	localparam int CFG_DEF_LSB = 0;
	localparam int CFG_DELAY_LSB = 8;
	localparam int CFG_DIAL_LSB = 16;
	localparam int LIM_VAL_LSB = 0;
	localparam int LIM_CMD_LSB = 16;
	localparam int LIM_SWB_BIT = 23;
	localparam int LIM_ALEN_BIT = 24;
	localparam int CAL_FRAC = 10;

	localparam logic [15:0] LIMIT_MIN = 16'hD8F1;
	localparam logic [15:0] LIMIT_MAX = 16'h270F;
	localparam logic [6:0] DELAY_DEF = 7'h01;
	localparam logic [6:0] DELAY_MIN = 7'h01;
	localparam logic [6:0] DELAY_MAX = 7'h63;
	localparam logic [6:0] CMD_NONE = 7'h00;
	localparam logic [6:0] CMD_MAX = 7'h63;
	localparam logic [3:0] DIAL_ALL = 4'h0;
	localparam logic [3:0] DIAL_MAX = 4'h9;
	localparam logic [15:0] CAL_DEF = 16'h0400;

	typedef enum {
		S_INIT,
		S_IDLE,
		S_APB_RD,
		S_APB_DONE,
		S_KEY_DO,
		S_EV_RD,
		S_EV_CMP
	} state_e;
endpackage

/* hdl/param_store.sv */
// Parameter memory: one write port, one read port with registered data
`timescale 1ns/1ps
module param_store #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 128
) (
	input wire logic clk_i,
	input wire logic we_i,
	input wire logic [$clog2(DEPTH)-1:0] waddr_i,
	input wire logic [WIDTH-1:0] wdata_i,
	input wire logic [$clog2(DEPTH)-1:0] raddr_i,
	output logic [WIDTH-1:0] rdata_o
);
	logic [WIDTH-1:0] mem [DEPTH];

	// No reset: the owner sweeps defaults in after reset
	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
		rdata_o <= mem[raddr_i];
	end
endmodule

/* hdl/second_tick.sv */
// Divider that turns the system clock into a one-cycle tick pulse
`timescale 1ns/1ps
module second_tick #(
	parameter int CYCLES = 125000000
) (
	input wire logic clk_i,
	input wire logic reset_i,
	output logic tick_o
);
	localparam int CW = (CYCLES > 2) ? $clog2(CYCLES) : 1;

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic tick;
	} tick_s;

	tick_s q;
	tick_s next_q;

	always_comb begin
		next_q = q;
		next_q.tick = 1'b0;
		if (q.cnt == CW'(CYCLES - 1)) begin
			next_q.cnt = '0;
			next_q.tick = 1'b1;
		end else begin
			next_q.cnt = q.cnt + CW'(1);
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	assign tick_o = q.tick;
endmodule
